// ==== eth_stream_consts.svh ====
`ifndef ETH_STREAM_CONSTS_SVH
`define ETH_STREAM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_TX_PKTS     8'h08
`define REG_RX_PKTS     8'h0c
`define REG_UNF_COUNT   8'h10

// ----------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_LSB   4
`define CTRL_MODE_MSB   5
`define CTRL_RESET      32'h0000_0000
`define COUNT_RESET     32'h0000_0000
`define STAT_UNF_BIT    0
`define STAT_TXPKT_BIT  1
`define STAT_RXPKT_BIT  2

// ----------------------------------------------------------------
// Straddled sideband layout
// ----------------------------------------------------------------
`define SB_WIDTH        70
`define SB_PRE_MSB      55
`define SB_S0_ENABLE    56
`define SB_S0_START     57
`define SB_S0_END       58
`define SB_S0_EMPTY_LSB 59
`define SB_S0_EMPTY_MSB 61
`define SB_S0_ERROR     62
`define SB_S1_ENABLE    63
`define SB_S1_START     64
`define SB_S1_END       65
`define SB_S1_EMPTY_LSB 66
`define SB_S1_EMPTY_MSB 68
`define SB_S1_ERROR     69

`endif

// ==== eth_stream_pkg.sv ====
package eth_stream_pkg;

  // Port variant selected by software
  typedef enum logic [1:0]
  {
    MODE_OFF      = 2'b00,
    MODE_STRADDLE = 2'b01,
    MODE_WIDE     = 2'b10,
    MODE_RAW      = 2'b11
  } mode_type;

  // Whole state of the port block
  typedef struct packed
  {
    logic           ahb_wr;
    logic [7:0]     ahb_addr;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           ena;
    mode_type       mode;
    logic [31:0]    tx_pkts;
    logic [31:0]    rx_pkts;
    logic [31:0]    unf_count;
    logic           tx_in_pkt;
    logic           rx_in_pkt;
    logic           unf;
    logic           tx_s_ready;
    logic           tx_w_ready;
    logic           core_tx_valid;
    logic [255:0]   core_tx_data;
    logic [31:0]    core_tx_keep;
    logic           core_tx_last;
    logic           core_tx_error;
    logic           core_tx_error_block;
    logic [55:0]    core_tx_preamble;
    logic [127:0]   core_tx_mii_d;
    logic [15:0]    core_tx_mii_c;
    logic           rx_s_valid;
    logic [127:0]   rx_s_data;
    logic [69:0]    rx_s_user;
    logic           rx_w_valid;
    logic [255:0]   rx_w_data;
    logic [31:0]    rx_w_keep;
    logic           rx_w_last;
    logic           rx_w_user;
    logic [127:0]   rx_mii_d;
    logic [15:0]    rx_mii_c;
  } state_type;

endpackage

// ==== seg_if.sv ====
`timescale 1ns/100ps
// Carries one 64-bit segment between byte keep and sideband fields
interface seg_if;
  logic [7:0] keep;
  logic       start_here;
  logic       end_here;
  logic       err;
  logic       enable;
  logic       start;
  logic       fin;
  logic [2:0] empty;
  logic       error;

  modport host
  (
    output keep, start_here, end_here, err,
    input  enable, start, fin, empty, error
  );
  modport enc
  (
    input  keep, start_here, end_here, err,
    output enable, start, fin, empty, error
  );
endinterface

// ==== seg_side_encoder.sv ====
`timescale 1ns/100ps
// Turns the byte keep of one segment into its sideband fields
module seg_side_encoder
(
  // Segment link
  seg_if.enc seg
);

  logic [2:0] zeros;

  // Unused bytes are the cleared keep lanes of the segment
  always_comb
  begin
    zeros = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (!seg.keep[i])
      begin
        zeros = zeros + 3'h1;
      end
    end
    seg.enable = |seg.keep;
    seg.start  = seg.enable & seg.start_here;
    seg.fin    = seg.enable & seg.end_here;
    seg.empty  = seg.fin ? zeros : 3'h0;
    seg.error  = seg.fin & seg.err;
  end

endmodule

// ==== eth_mac_user_stream_port.sv ====
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "eth_stream_consts.svh"
module eth_mac_user_stream_port
(
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite register slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Straddled transmit stream
  input  wire logic         tx_s_valid,
  input  wire logic [127:0] tx_s_data,
  input  wire logic [69:0]  tx_s_user,
  output logic              tx_s_ready,
  output logic              tx_underflow,
  // Straddled receive stream
  output logic              rx_s_valid,
  output logic      [127:0] rx_s_data,
  output logic      [69:0]  rx_s_user,
  // Wide transmit stream
  input  wire logic         tx_w_valid,
  input  wire logic [255:0] tx_w_data,
  input  wire logic [31:0]  tx_w_keep,
  input  wire logic         tx_w_last,
  input  wire logic         tx_w_user,
  output logic              tx_w_ready,
  // Wide receive stream
  output logic              rx_w_valid,
  output logic      [255:0] rx_w_data,
  output logic      [31:0]  rx_w_keep,
  output logic              rx_w_last,
  output logic              rx_w_user,
  // Raw media word port
  input  wire logic [127:0] tx_mii_d,
  input  wire logic [15:0]  tx_mii_c,
  output logic      [127:0] rx_mii_d,
  output logic      [15:0]  rx_mii_c,
  // Core side transmit
  input  wire logic         core_tx_ready,
  output logic              core_tx_valid,
  output logic      [255:0] core_tx_data,
  output logic      [31:0]  core_tx_keep,
  output logic              core_tx_last,
  output logic              core_tx_error,
  output logic              core_tx_error_block,
  output logic      [55:0]  core_tx_preamble,
  output logic      [127:0] core_tx_mii_d,
  output logic      [15:0]  core_tx_mii_c,
  // Core side receive
  input  wire logic         core_rx_valid,
  input  wire logic [255:0] core_rx_data,
  input  wire logic [31:0]  core_rx_keep,
  input  wire logic         core_rx_last,
  input  wire logic         core_rx_error,
  input  wire logic [55:0]  core_rx_preamble,
  input  wire logic [127:0] core_rx_mii_d,
  input  wire logic [15:0]  core_rx_mii_c
);

  import eth_stream_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_type  st;
  state_type  next_st;
  logic       ahb_sel;
  logic       straddle;
  logic       wide;
  logic       raw;
  logic       fire_s;
  logic       fire_w;
  logic       unf_now;
  logic       s0_start;
  logic       s0_end;
  logic       s1_start;
  logic       s1_end;
  logic [7:0] k0;
  logic [7:0] k1;
  logic       rx_s_beat;
  logic       rx_w_beat;

  seg_if seg0 ();
  seg_if seg1 ();

  // Keep of one transmit segment from its enable, end and empty
  function automatic logic [7:0] seg_keep
  (
    input logic       en,
    input logic       fin,
    input logic [2:0] empty
  );
    logic [7:0] k;
    k = 8'hff;
    if (!en)
    begin
      k = 8'h00;
    end
    else if (fin)
    begin
      k = 8'hff >> empty;
    end
    return k;
  endfunction

  // ----------------------------------------------------------------
  // Variant decode and receive segment encoders
  // ----------------------------------------------------------------

  // Only the selected variant's port is live
  assign straddle = st.ena && (st.mode == MODE_STRADDLE);
  assign wide     = st.ena && (st.mode == MODE_WIDE);
  assign raw      = st.ena && (st.mode == MODE_RAW);

  // A beat moves only while valid meets the registered ready
  assign fire_s = st.tx_s_ready & tx_s_valid;
  assign fire_w = st.tx_w_ready & tx_w_valid;

  // Inside a packet; ready offered but nothing given is tested where this is used
  assign unf_now = st.tx_in_pkt;

  // Receive core beat split into two 64-bit segments
  assign k0 = core_rx_keep[7:0];
  assign k1 = core_rx_keep[15:8];
  assign s0_start = ~st.rx_in_pkt & (|k0);
  assign s1_start = ~st.rx_in_pkt & ~(|k0) & (|k1);
  assign s0_end   = core_rx_last & (|k0) & ~(|k1);
  assign s1_end   = core_rx_last & (|k1);

  assign seg0.keep       = k0;
  assign seg0.start_here = s0_start;
  assign seg0.end_here   = s0_end;
  assign seg0.err        = core_rx_error;
  assign seg1.keep       = k1;
  assign seg1.start_here = s1_start;
  assign seg1.end_here   = s1_end;
  assign seg1.err        = core_rx_error;

  seg_side_encoder u_seg0
  (
    .seg (seg0)
  );

  seg_side_encoder u_seg1
  (
    .seg (seg1)
  );

  assign ahb_sel   = hsel & htrans[1] & hready;
  assign rx_s_beat = straddle & core_rx_valid & (|core_rx_keep[15:0]);
  assign rx_w_beat = wide & core_rx_valid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Register bus, transmit, receive and counters
  always_comb
  begin
    next_st = st;

    // AHB address phase capture and zero-wait read data
    next_st.hreadyout = 1'b1;
    next_st.ahb_wr    = ahb_sel & hwrite;
    next_st.ahb_addr  = haddr[7:0];
    next_st.hrdata    = 32'h0000_0000;
    if (ahb_sel && !hwrite)
    begin
      if (haddr[7:0] == `REG_CTRL)
      begin
        next_st.hrdata[`CTRL_ENABLE_BIT] = st.ena;
        next_st.hrdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = st.mode;
      end
      else if (haddr[7:0] == `REG_STATUS)
      begin
        next_st.hrdata[`STAT_UNF_BIT]   = st.unf;
        next_st.hrdata[`STAT_TXPKT_BIT] = st.tx_in_pkt;
        next_st.hrdata[`STAT_RXPKT_BIT] = st.rx_in_pkt;
      end
      else if (haddr[7:0] == `REG_TX_PKTS)
      begin
        next_st.hrdata = st.tx_pkts;
      end
      else if (haddr[7:0] == `REG_RX_PKTS)
      begin
        next_st.hrdata = st.rx_pkts;
      end
      else if (haddr[7:0] == `REG_UNF_COUNT)
      begin
        next_st.hrdata = st.unf_count;
      end
    end

    // AHB data phase write to the control register
    if (st.ahb_wr && (st.ahb_addr == `REG_CTRL))
    begin
      next_st.ena  = hwdata[`CTRL_ENABLE_BIT];
      next_st.mode = mode_type'(hwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      next_st.tx_in_pkt = 1'b0;
      next_st.rx_in_pkt = 1'b0;
    end

    // Ready follows the core's pacing in the selected variant
    next_st.tx_s_ready = straddle & core_tx_ready;
    next_st.tx_w_ready = wide & core_tx_ready;

    // Transmit beats towards the core
    next_st.core_tx_valid       = 1'b0;
    next_st.core_tx_error_block = 1'b0;
    next_st.unf                 = 1'b0;
    if (fire_s)
    begin
      next_st.core_tx_valid = 1'b1;
      next_st.core_tx_data  = {128'h0, tx_s_data};
      next_st.core_tx_keep  =
        {16'h0000,
         seg_keep(tx_s_user[`SB_S1_ENABLE], tx_s_user[`SB_S1_END],
                  tx_s_user[`SB_S1_EMPTY_MSB:`SB_S1_EMPTY_LSB]),
         seg_keep(tx_s_user[`SB_S0_ENABLE], tx_s_user[`SB_S0_END],
                  tx_s_user[`SB_S0_EMPTY_MSB:`SB_S0_EMPTY_LSB])};
      next_st.core_tx_last  = (tx_s_user[`SB_S0_ENABLE]
                               & tx_s_user[`SB_S0_END])
                              | (tx_s_user[`SB_S1_ENABLE]
                               & tx_s_user[`SB_S1_END]);
      next_st.core_tx_error = (tx_s_user[`SB_S0_END]
                               & tx_s_user[`SB_S0_ERROR])
                              | (tx_s_user[`SB_S1_END]
                               & tx_s_user[`SB_S1_ERROR]);
      next_st.core_tx_preamble = tx_s_user[`SB_PRE_MSB:0];
      // Packet boundary tracking; a segment 1 start reopens
      if (tx_s_user[`SB_S1_ENABLE] && tx_s_user[`SB_S1_END])
      begin
        next_st.tx_in_pkt = 1'b0;
      end
      else if (tx_s_user[`SB_S1_ENABLE] && tx_s_user[`SB_S1_START])
      begin
        next_st.tx_in_pkt = 1'b1;
      end
      else if (tx_s_user[`SB_S0_ENABLE] && tx_s_user[`SB_S0_END])
      begin
        next_st.tx_in_pkt = 1'b0;
      end
      else if (tx_s_user[`SB_S0_ENABLE] && tx_s_user[`SB_S0_START])
      begin
        next_st.tx_in_pkt = 1'b1;
      end
    end
    else if (fire_w)
    begin
      next_st.core_tx_valid = 1'b1;
      next_st.core_tx_data  = tx_w_data;
      next_st.core_tx_keep  = tx_w_keep;
      next_st.core_tx_last  = tx_w_last;
      next_st.core_tx_error = tx_w_user;
      next_st.tx_in_pkt     = ~tx_w_last;
    end
    else if (unf_now && (st.tx_s_ready || st.tx_w_ready))
    begin
      // Starved mid-packet: corrupt it with error blocks
      next_st.unf                 = 1'b1;
      next_st.core_tx_valid       = 1'b1;
      next_st.core_tx_error_block = 1'b1;
      next_st.core_tx_error       = 1'b1;
      next_st.core_tx_keep        = 32'h0000_0000;
      next_st.core_tx_last        = 1'b0;
    end

    // Transmit packet and underflow event counters
    if ((fire_s || fire_w) && next_st.core_tx_last)
    begin
      next_st.tx_pkts = st.tx_pkts + 32'h0000_0001;
    end
    if (next_st.unf && !st.unf)
    begin
      next_st.unf_count = st.unf_count + 32'h0000_0001;
    end

    // Raw media words pass through only in raw mode
    next_st.core_tx_mii_d = raw ? tx_mii_d : 128'h0;
    next_st.core_tx_mii_c = raw ? tx_mii_c : 16'h0000;
    next_st.rx_mii_d      = raw ? core_rx_mii_d : 128'h0;
    next_st.rx_mii_c      = raw ? core_rx_mii_c : 16'h0000;

    // Straddled receive beat with built sideband
    next_st.rx_s_valid = rx_s_beat;
    if (rx_s_beat)
    begin
      next_st.rx_s_data = core_rx_data[127:0];
      next_st.rx_s_user =
        {seg1.error, seg1.empty, seg1.fin, seg1.start, seg1.enable,
         seg0.error, seg0.empty, seg0.fin, seg0.start, seg0.enable,
         core_rx_preamble};
      next_st.rx_in_pkt = ~core_rx_last;
    end

    // Wide receive beat
    next_st.rx_w_valid = rx_w_beat;
    if (rx_w_beat)
    begin
      next_st.rx_w_data = core_rx_data;
      next_st.rx_w_keep = core_rx_keep;
      next_st.rx_w_last = core_rx_last;
      next_st.rx_w_user = core_rx_error;
      next_st.rx_in_pkt = ~core_rx_last;
    end

    // Receive packet counter
    if ((rx_s_beat || rx_w_beat) && core_rx_last)
    begin
      next_st.rx_pkts = st.rx_pkts + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // All state registered together
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st           <= '0;
      st.mode      <= MODE_OFF;
      st.hreadyout <= 1'b1;
      st.tx_pkts   <= `COUNT_RESET;
      st.rx_pkts   <= `COUNT_RESET;
      st.unf_count <= `COUNT_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output except hresp, tied low, is a state flip-flop
  assign hrdata              = st.hrdata;
  assign hreadyout           = st.hreadyout;
  assign hresp               = 1'b0;
  assign tx_s_ready          = st.tx_s_ready;
  assign tx_underflow        = st.unf;
  assign rx_s_valid          = st.rx_s_valid;
  assign rx_s_data           = st.rx_s_data;
  assign rx_s_user           = st.rx_s_user;
  assign tx_w_ready          = st.tx_w_ready;
  assign rx_w_valid          = st.rx_w_valid;
  assign rx_w_data           = st.rx_w_data;
  assign rx_w_keep           = st.rx_w_keep;
  assign rx_w_last           = st.rx_w_last;
  assign rx_w_user           = st.rx_w_user;
  assign rx_mii_d            = st.rx_mii_d;
  assign rx_mii_c            = st.rx_mii_c;
  assign core_tx_valid       = st.core_tx_valid;
  assign core_tx_data        = st.core_tx_data;
  assign core_tx_keep        = st.core_tx_keep;
  assign core_tx_last        = st.core_tx_last;
  assign core_tx_error       = st.core_tx_error;
  assign core_tx_error_block = st.core_tx_error_block;
  assign core_tx_preamble    = st.core_tx_preamble;
  assign core_tx_mii_d       = st.core_tx_mii_d;
  assign core_tx_mii_c       = st.core_tx_mii_c;

endmodule

// ==== eth_port_monitor.sv ====
`timescale 1ns/100ps
module eth_port_monitor
(
  // Clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  // User transmit streams
  input wire logic         tx_s_valid,
  input wire logic [127:0] tx_s_data,
  input wire logic [69:0]  tx_s_user,
  input wire logic         tx_s_ready,
  input wire logic         tx_underflow,
  input wire logic         tx_w_valid,
  input wire logic [255:0] tx_w_data,
  input wire logic         tx_w_last,
  input wire logic         tx_w_user,
  input wire logic         tx_w_ready,
  // Core transmit
  input wire logic         core_tx_ready,
  input wire logic         core_tx_valid,
  input wire logic [255:0] core_tx_data,
  input wire logic         core_tx_last,
  input wire logic         core_tx_error,
  input wire logic         core_tx_error_block,
  input wire logic [55:0]  core_tx_preamble,
  // Receive paths
  input wire logic         core_rx_valid,
  input wire logic [255:0] core_rx_data,
  input wire logic         core_rx_last,
  input wire logic         core_rx_error,
  input wire logic [55:0]  core_rx_preamble,
  input wire logic         rx_s_valid,
  input wire logic [127:0] rx_s_data,
  input wire logic [69:0]  rx_s_user,
  input wire logic         rx_w_valid,
  input wire logic [255:0] rx_w_data,
  input wire logic         rx_w_last,
  input wire logic         rx_w_user
);
  // ----------------------------------------------------------------
  // Stream port checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_ready_excl:
    assert property (!(tx_s_ready && tx_w_ready))
    else $error("both stream variants ready at once");
  chk_wide_ready:
    assert property (tx_w_ready |-> $past(core_tx_ready))
    else $error("wide ready without core ready");
  chk_wide_beat:
    assert property (tx_w_valid && tx_w_ready |=> core_tx_valid &&
      core_tx_data == $past(tx_w_data) && core_tx_last == $past(tx_w_last))
    else $error("wide beat not passed on");
  chk_wide_error:
    assert property (tx_w_valid && tx_w_ready |=>
      core_tx_error == $past(tx_w_user))
    else $error("wide bad flag lost");
  chk_strad_beat:
    assert property (tx_s_valid && tx_s_ready |=> core_tx_valid &&
      core_tx_data[127:0] == $past(tx_s_data) &&
      core_tx_preamble == $past(tx_s_user[55:0]))
    else $error("straddled beat not passed on");
  chk_unf_blocks:
    assert property (tx_underflow |->
      core_tx_valid && core_tx_error && core_tx_error_block)
    else $error("underflow without error block");
  chk_unf_cause:
    assert property (tx_underflow |-> !$past(tx_w_valid) && !$past(tx_s_valid))
    else $error("underflow while data offered");
  chk_rx_wide:
    assert property (rx_w_valid |-> $past(core_rx_valid) &&
      rx_w_data == $past(core_rx_data) && rx_w_last == $past(core_rx_last) &&
      rx_w_user == $past(core_rx_error))
    else $error("wide receive beat wrong");
  chk_rx_strad:
    assert property (rx_s_valid |-> $past(core_rx_valid) &&
      rx_s_data == $past(core_rx_data[127:0]) &&
      rx_s_user[55:0] == $past(core_rx_preamble))
    else $error("straddled receive beat wrong");
  chk_seg_idle:
    assert property (rx_s_valid && !rx_s_user[63] |-> rx_s_user[69:64] == 6'h0)
    else $error("disabled segment carries flags");

  // Main scenarios
  cover property (tx_w_valid && tx_w_ready && tx_w_last);
  cover property (tx_underflow);
  cover property (rx_s_valid && rx_s_user[65]);
endmodule

bind eth_mac_user_stream_port eth_port_monitor i_mon (.*);

// ==== user_wide_source.sv ====
`timescale 1ns/100ps
// User logic feeding the wide transmit stream
module user_wide_source
(
  // Clock
  input  wire logic         hclk,
  // Wide transmit stream
  input  wire logic         tx_w_ready,
  output logic              tx_w_valid,
  output logic      [255:0] tx_w_data,
  output logic      [31:0]  tx_w_keep,
  output logic              tx_w_last,
  output logic              tx_w_user
);
  // Quiet at time zero
  initial
  begin
    tx_w_valid = 1'b0;
    tx_w_data  = '0;
    tx_w_keep  = '0;
    tx_w_last  = 1'b0;
    tx_w_user  = 1'b0;
  end

  // Offers one beat and holds it until the device takes it
  task automatic beat(input logic [255:0] d, input logic [31:0] k,
                      input logic l, input logic u);
    tx_w_valid <= 1'b1;
    tx_w_data  <= d;
    tx_w_keep  <= k;
    tx_w_last  <= l;
    tx_w_user  <= u;
    do @(posedge hclk); while (tx_w_ready !== 1'b1);
  endtask

  // Released data and keep lines show the inverse of their last value
  task automatic idle();
    tx_w_valid <= 1'b0;
    tx_w_data  <= ~tx_w_data;
    tx_w_keep  <= ~tx_w_keep;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
`include "eth_stream_consts.svh"
module testbench;
  import eth_stream_pkg::*;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic         tx_s_valid, tx_s_ready, tx_underflow, rx_s_valid;
  logic [127:0] tx_s_data, rx_s_data, tx_mii_d, rx_mii_d;
  logic [127:0] core_tx_mii_d, core_rx_mii_d;
  logic [69:0]  tx_s_user, rx_s_user;
  logic         tx_w_valid, tx_w_last, tx_w_user, tx_w_ready;
  logic         rx_w_valid, rx_w_last, rx_w_user, narrow;
  logic [255:0] tx_w_data, rx_w_data, core_tx_data, core_rx_data, r;
  logic [31:0]  tx_w_keep, rx_w_keep, core_tx_keep, core_rx_keep;
  logic [15:0]  tx_mii_c, rx_mii_c, core_tx_mii_c, core_rx_mii_c;
  logic         core_tx_ready, core_tx_valid, core_tx_last, core_tx_error;
  logic         core_tx_error_block, core_rx_valid, core_rx_last;
  logic         core_rx_error;
  logic [55:0]  core_tx_preamble, core_rx_preamble;
  logic [289:0] exp_q[$];
  int           n_fail, n_checks, n_unf;

  assign hready = hreadyout;

  eth_mac_user_stream_port i_dut (.*);

  user_wide_source i_src (.*);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [289:0] got, input logic [289:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [255:0] rnd();
    for (int i = 0; i < 8; i++)
      rnd[i*32 +: 32] = $urandom();
  endfunction

  // Single AHB transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Wide packet of nb beats, optional stall after the first
  task automatic txw(input int nb, input int gap, input logic bad);
    logic [31:0] k;
    for (int i = 0; i < nb; i++)
    begin
      r = rnd();
      k = (i == nb - 1) ? 32'hffff_ffff >> ($urandom() % 32) : '1;
      exp_q.push_back({i == nb - 1, bad, k, r});
      i_src.beat(r, k, i == nb - 1, bad);
      if (i == 0 && gap > 0)
      begin
        i_src.idle();
        repeat (gap) @(posedge hclk);
      end
    end
    i_src.idle();
    @(posedge hclk);
  endtask

  // Single-beat straddled packet ending in segment 0
  task automatic txs(input logic [2:0] e3, input logic err);
    r = rnd();
    exp_q.push_back({1'b1, err, 24'h0, 8'hff >> e3, 128'h0, r[127:0]});
    tx_s_valid <= 1'b1;
    tx_s_data  <= r[127:0];
    tx_s_user  <= {7'h0, err, e3, 3'b111, r[255:200]};
    do @(posedge hclk); while (tx_s_ready !== 1'b1);
    tx_s_valid <= 1'b0;
    tx_s_data  <= ~r[127:0];
    @(posedge hclk);
  endtask

  // One receive beat, compared with the active variant's outputs
  task automatic rxb(input logic [31:0] k, input logic l, input logic e,
                     input logic [13:0] sb);
    r = rnd();
    core_rx_valid    <= 1'b1;
    core_rx_data     <= r;
    core_rx_keep     <= k;
    core_rx_last     <= l;
    core_rx_error    <= e;
    core_rx_preamble <= r[255:200];
    @(posedge hclk);
    core_rx_valid <= 1'b0;
    core_rx_data  <= ~r;
    @(posedge hclk);
    if (narrow)
      chk({rx_s_valid, rx_s_user, rx_s_data}, {1'b1, sb, r[255:200],
          r[127:0]});
    else
      chk({rx_w_valid, rx_w_last, rx_w_user, rx_w_keep, rx_w_data},
          {1'b1, l, e, k, r});
  endtask

  // Model of the core transmit side, compared at every beat except underflow beats
  always @(posedge hclk)
  begin
    if (tx_underflow === 1'b1)
      n_unf++;
    else if (hresetn && core_tx_valid === 1'b1)
      chk({core_tx_last, core_tx_error, core_tx_keep, narrow ?
          {128'h0, core_tx_data[127:0]} : core_tx_data},
          exp_q.size() ? exp_q.pop_front() : '1);
  end

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    summarize();
  end

  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, tx_s_valid} = '0;
    {tx_s_data, tx_s_user, tx_mii_d, tx_mii_c, core_tx_ready} = '0;
    {core_rx_valid, core_rx_data, core_rx_keep, core_rx_last} = '0;
    {core_rx_error, core_rx_preamble, core_rx_mii_d, core_rx_mii_c} = '0;
    {narrow, n_fail, n_checks, n_unf} = '0;
    hsize = 3'h2;
    void'($urandom(32'h9c09));
    repeat (3) @(posedge hclk);
    chk({hreadyout, hresp, tx_s_ready, tx_w_ready, rx_w_valid}, 5'h10);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 32'h0000_0020, 32'hffff_ffff);
    foreach (r[i]) if (i < 5) rd_chk(i == 4 ? 32'h20 : i * 4, 32'h0);
    $display("test reset done");
    ahb(1'b1, `REG_CTRL, {26'h0, MODE_WIDE, 4'h1});
    core_tx_ready <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({tx_w_ready, tx_s_ready}, 2'b10);
    txw(3, 0, 1'b0);
    rd_chk(`REG_TX_PKTS, 32'h1);
    chk(n_unf, 0);
    txw(3, 2, 1'b1);
    chk(n_unf, 2);
    rd_chk(`REG_UNF_COUNT, 32'h1);
    core_tx_ready <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(tx_w_ready, 1'b0);
    core_tx_ready <= 1'b1;
    rxb('1, 1'b0, 1'b0, 14'h0);
    rxb(32'h0000_ffff, 1'b1, 1'b1, 14'h0);
    rd_chk(`REG_RX_PKTS, 32'h1);
    $display("test wide done");
    ahb(1'b1, `REG_CTRL, {26'h0, MODE_STRADDLE, 4'h1});
    narrow = 1'b1;
    repeat (2) @(posedge hclk);
    chk({tx_w_ready, tx_s_ready}, 2'b01);
    for (int e = 0; e < 8; e++) txs(e[2:0], e[0]);
    rxb(32'h0000_007f, 1'b1, 1'b1, 14'h004f);
    rxb(32'h0000_ffff, 1'b0, 1'b0, 14'h0083);
    rxb(32'h0000_0fff, 1'b1, 1'b0, 14'h1281);
    $display("test straddled done");
    ahb(1'b1, `REG_CTRL, {26'h0, MODE_RAW, 4'h1});
    r = rnd();
    tx_mii_d      <= r[127:0];
    tx_mii_c      <= r[143:128];
    core_rx_mii_d <= r[255:128];
    core_rx_mii_c <= r[15:0];
    repeat (2) @(posedge hclk);
    chk({core_tx_mii_d, core_tx_mii_c, rx_mii_d, rx_mii_c},
        {r[127:0], r[143:128], r[255:128], r[15:0]});
    chk({tx_w_ready, tx_s_ready}, 2'b00);
    $display("test raw done");
    summarize();
  end
endmodule
